// >>> hw/rbos_pkg.sv
// Shared constants and types of the reset, option byte and security block
package rbos_pkg;

    // Option byte layout
    localparam int OPT_BOOT_FLASH_BIT = 0;
    localparam int OPT_HALT_OFF_BIT   = 1;
    localparam int OPT_WD_OFF_BIT     = 2;
    localparam int OPT_SECURE_BIT     = 5;
    localparam logic [7:0] OPT_ERASED = 8'h00;

    // External flash addresses
    localparam logic [15:0] OPT_PHYS_ADDR  = 16'h3FFF;
    localparam logic [15:0] OPT_ALIAS_ADDR = 16'hFFFF;
    localparam logic [7:0]  SECURE_FILL    = 8'hFF;

    // Core and peripheral reset values
    localparam logic [15:0] PC_RESET     = 16'h0000;
    localparam logic [7:0]  CLEARED      = 8'h00;
    localparam logic [7:0]  IDLE_TIMER_CTRL_REG_RESET   = 8'h40;
    localparam logic [7:0]  SP_RESET     = 8'h6F;
    localparam int          TX_BUFFER_EMPTY_BIT     = 1;
    localparam logic [7:0]  USART_RESET  = 8'h02;
    localparam logic [7:0]  PROGRAM_TIMING_REG_10MHZ = 8'h00;
    localparam logic [1:0]  WD_WIN_MAX   = 2'h3;

    // Timing
    localparam int MCLK_HZ          = 25_000_000;
    localparam int POWERUP_DELAY_MS = 3;
    localparam int POWERUP_DELAY_CYC = POWERUP_DELAY_MS * (MCLK_HZ / 1000);
    localparam logic [15:0] IDLE_PRESET = 16'h00FF;
    localparam logic [4:0]  CM_RECOVER_TICKS = 5'h10;

    // Programmer commands, one-hot
    typedef enum logic [3:0] {
        CMD_READ       = 4'h1,
        CMD_WRITE      = 4'h2,
        CMD_PAGE_ERASE = 4'h4,
        CMD_MASS_ERASE = 4'h8
    } rbos_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_DONE = 3'h4
    } rbos_state_t;

    typedef struct packed {
        logic        valid;
        rbos_cmd_t   cmd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } rbos_req_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        page_erase;
        logic        mass_erase;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } rbos_flash_op_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0]  processor_status_reg;
        logic [7:0]  timer1_serial_ctrl_reg;
        logic [7:0]  interrupt_ctrl_reg;
        logic [7:0]  timer2_ctrl_reg;
        logic [7:0]  fast_timer_ctrl_reg;
        logic [7:0]  segment_reg;
        logic [7:0]  wakeup_enable_reg;
        logic [7:0]  wakeup_edge_reg;
        logic [7:0]  idle_timer_ctrl_reg;
        logic [7:0]  stack_ptr;
        logic [7:0]  baud_prescale_reg;
        logic [7:0]  usart_ctrl_reg;
        logic [7:0]  usart_rx_ctrl_reg;
        logic [7:0]  usart_irq_ctrl_reg;
        logic [7:0]  isp_addr_low_reg;
        logic [7:0]  isp_addr_high_reg;
        logic [7:0]  program_timing_reg;
        logic [1:0]  wd_window;
    } rbos_reset_vals_t;

    typedef struct packed {
        logic        delay_run;
        logic [31:0] delay_cnt;
        logic [15:0] idle_cnt;
        logic        hold;
    } rbos_timer_state_t;

endpackage : rbos_pkg

// >>> hw/rbos_start_timer.sv
// Brownout hold timer: power-up delay then idle timer countdown
`timescale 1ns/100ps
module rbos_start_timer
    import rbos_pkg::*;
#(
    parameter bit HAS_BOR   = 1'b1,
    parameter int DELAY_CYC = POWERUP_DELAY_CYC
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Supply monitor and instruction-cycle tick
    input  wire logic above_trigger,
    input  wire logic above_bor,
    input  wire logic tc_tick,
    // Internal reset request
    output logic      bor_hold
);

    rbos_timer_state_t state;
    rbos_timer_state_t next_state;

    always_comb begin
        next_state = state;
        if (!above_trigger) begin
            // Every rise past the trigger restarts the delay
            next_state.delay_run = 1'b1;
            next_state.delay_cnt = 32'(DELAY_CYC);
        end else if (state.delay_cnt != 32'h0) begin
            next_state.delay_cnt = state.delay_cnt - 32'h1;
        end else begin
            next_state.delay_run = 1'b0;
        end
        if (!above_bor || !above_trigger) begin
            next_state.hold     = 1'b1;
            next_state.idle_cnt = IDLE_PRESET;
        end else if (state.hold && !state.delay_run
                     && state.delay_cnt == 32'h0 && tc_tick) begin
            if (state.idle_cnt == 16'h0000) begin
                next_state.hold = 1'b0;
            end else begin
                next_state.idle_cnt = state.idle_cnt - 16'h0001;
            end
        end
        if (!HAS_BOR) begin
            next_state.hold = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= '{delay_run: 1'b1, delay_cnt: 32'h0,
                       idle_cnt: IDLE_PRESET, hold: 1'b1};
        end else begin
            state <= next_state;
        end
    end

    assign bor_hold = state.hold;

endmodule : rbos_start_timer

// >>> hw/rbos_reset_ctrl.sv
// Reset merge, option byte decode and flash security gating
`timescale 1ns/100ps
module rbos_reset_ctrl
    import rbos_pkg::*;
#(
    parameter bit        HAS_BOR       = 1'b1,
    parameter int        DELAY_CYC     = POWERUP_DELAY_CYC,
    parameter int        TC_DIV        = 1,
    parameter logic [7:0] PROGRAM_TIMING_REG_VALUE = PROGRAM_TIMING_REG_10MHZ
) (
    // Clock and block reset
    input  wire logic           mclk,
    input  wire logic           rst_n,
    // Reset sources
    input  wire logic           reset_pin_n,
    input  wire logic           above_trigger,
    input  wire logic           above_bor,
    // Nonvolatile option byte as stored in flash
    input  wire logic [7:0]     nonvolatile_option_byte,
    // Watchdog and clock monitor
    input  wire logic           t0_tick,
    input  wire logic           clk_too_slow,
    input  wire logic           gpio_g1_out,
    input  wire logic           gpio_g1_oe,
    // Programmer port
    input  wire rbos_req_t      ext_req,
    input  wire logic           isp_user_mode,
    input  wire logic [7:0]     flash_rdata,
    output rbos_flash_op_t      flash_op,
    output logic                ext_ready,
    output logic                ext_done,
    output logic                ext_refused,
    output logic [7:0]          ext_rdata,
    // Core reset and decoded options
    output logic                core_reset,
    output rbos_reset_vals_t    reset_vals,
    output logic                halt_allowed,
    output logic                boot_from_flash,
    output logic                secure,
    output logic                wd_armed,
    // Pins
    output logic                ports_force_input,
    output logic                g0_pullup,
    output logic                g2_pullup,
    output logic                watchdog_error_pin_out,
    output logic                watchdog_error_pin_oe
);

    typedef struct packed {
        rbos_state_t      st;
        logic             core_reset;
        logic [7:0]       opt;
        rbos_reset_vals_t rv;
        rbos_flash_op_t   op;
        logic             done;
        logic             refused;
        logic [7:0]       rdata;
        logic             cm_err;
        logic [4:0]       cm_cnt;
        logic [15:0]      tc_cnt;
        logic             wd_armed;
        logic             g1_out;
        logic             g1_oe;
        logic             ready;
        logic             halt_ok;
        logic             boot_flash;
        logic             sec;
    } rbos_ctrl_state_t;

    rbos_ctrl_state_t state;
    rbos_ctrl_state_t next_state;
    logic             bor_hold;
    logic             tc_tick;
    logic             raw_reset;
    logic             wd_on;
    logic             locked;

    rbos_start_timer #(
        .HAS_BOR   (HAS_BOR),
        .DELAY_CYC (DELAY_CYC)
    ) u_start_timer (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .above_trigger (above_trigger),
        .above_bor     (above_bor),
        .tc_tick       (tc_tick),
        .bor_hold      (bor_hold)
    );

    // The instruction cycle rate is an enable from a divider
    assign tc_tick   = (state.tc_cnt == 16'(TC_DIV - 1));
    assign raw_reset = !reset_pin_n || (HAS_BOR && bor_hold);
    assign wd_on     = !state.opt[OPT_WD_OFF_BIT];
    // User ISP code runs under its own policy and bypasses gating
    assign locked    = state.opt[OPT_SECURE_BIT] && !isp_user_mode;

    function automatic rbos_reset_vals_t reset_image();
        rbos_reset_vals_t v;
        v.pc                     = PC_RESET;
        v.processor_status_reg   = CLEARED;
        v.timer1_serial_ctrl_reg = CLEARED;
        v.interrupt_ctrl_reg     = CLEARED;
        v.timer2_ctrl_reg        = CLEARED;
        v.fast_timer_ctrl_reg    = CLEARED;
        v.segment_reg            = CLEARED;
        v.wakeup_enable_reg      = CLEARED;
        v.wakeup_edge_reg        = CLEARED;
        v.idle_timer_ctrl_reg    = IDLE_TIMER_CTRL_REG_RESET;
        v.stack_ptr              = SP_RESET;
        v.baud_prescale_reg      = CLEARED;
        v.usart_ctrl_reg         = USART_RESET;
        v.usart_rx_ctrl_reg      = CLEARED;
        v.usart_irq_ctrl_reg     = CLEARED;
        v.isp_addr_low_reg       = CLEARED;
        v.isp_addr_high_reg      = CLEARED;
        v.program_timing_reg     = PROGRAM_TIMING_REG_VALUE;
        v.wd_window              = WD_WIN_MAX;
        return v;
    endfunction : reset_image

    always_comb begin
        next_state         = state;
        next_state.op.rd         = 1'b0;
        next_state.op.wr         = 1'b0;
        next_state.op.page_erase = 1'b0;
        next_state.op.mass_erase = 1'b0;
        next_state.done    = 1'b0;
        next_state.refused = 1'b0;
        next_state.tc_cnt  = tc_tick ? 16'h0000 : state.tc_cnt + 16'h0001;

        // Registered merge so every consumer sees one clean edge
        next_state.core_reset = raw_reset;
        if (state.core_reset) begin
            // Option byte is reloaded while in reset
            next_state.opt = nonvolatile_option_byte;
            // Retained state (shift reg, pointers, RAM) is not driven here
            next_state.rv  = reset_image();
        end

        // Watchdog stays inhibited for the whole reset
        // Taken from the raw merge so arming never overlaps core_reset
        next_state.wd_armed = !raw_reset && wd_on;

        // Clock monitor: error holds until recovery lasts the tick count
        if (state.wd_armed && clk_too_slow) begin
            next_state.cm_err = 1'b1;
            next_state.cm_cnt = 5'h00;
        end else if (state.cm_err && t0_tick) begin
            if (state.cm_cnt == CM_RECOVER_TICKS - 5'h01) begin
                next_state.cm_err = 1'b0;
            end else begin
                next_state.cm_cnt = state.cm_cnt + 5'h01;
            end
        end
        if (!wd_on) begin
            next_state.cm_err = 1'b0;
        end

        // G1 belongs to the watchdog whenever the option enables it
        if (wd_on) begin
            next_state.g1_oe  = 1'b1;
            next_state.g1_out = !next_state.cm_err;
        end else if (state.core_reset) begin
            next_state.g1_oe  = 1'b0;
            next_state.g1_out = 1'b0;
        end else begin
            next_state.g1_oe  = gpio_g1_oe;
            next_state.g1_out = gpio_g1_out;
        end

        case (state.st)
            ST_IDLE: begin
                if (ext_req.valid) begin
                    next_state.op.addr  = ext_req.addr;
                    next_state.op.wdata = ext_req.wdata;
                    next_state.st       = ST_DONE;
                    case (ext_req.cmd)
                        CMD_READ: begin
                            if (ext_req.addr == OPT_ALIAS_ADDR) begin
                                next_state.rdata = state.opt;
                            end else if (locked
                                    && ext_req.addr != OPT_PHYS_ADDR) begin
                                next_state.rdata = SECURE_FILL;
                            end else begin
                                next_state.op.rd = 1'b1;
                                next_state.st    = ST_WAIT;
                            end
                        end
                        CMD_WRITE: begin
                            // Whole-byte option writes rely on the programmer
                            if (locked) begin
                                next_state.refused = 1'b1;
                            end else begin
                                next_state.op.wr = 1'b1;
                            end
                        end
                        CMD_PAGE_ERASE: begin
                            if (locked) begin
                                next_state.refused = 1'b1;
                            end else begin
                                next_state.op.page_erase = 1'b1;
                            end
                        end
                        CMD_MASS_ERASE: begin
                            next_state.op.mass_erase = 1'b1;
                            next_state.opt = OPT_ERASED;
                        end
                        default: begin
                            next_state.refused = 1'b1;
                        end
                    endcase
                end
            end
            ST_WAIT: begin
                // Array answers in the same cycle as the read strobe
                next_state.st = ST_DONE;
            end
            ST_DONE: begin
                if (state.op.rd == 1'b0 && state.rdata != flash_rdata) begin
                    next_state.rdata = state.rdata;
                end
                next_state.done = 1'b1;
                next_state.st   = ST_IDLE;
            end
            default: begin
                next_state.st = ST_IDLE;
            end
        endcase
        if (state.st == ST_WAIT) begin
            next_state.rdata = flash_rdata;
        end

        // Decoded levels are registered here so that every
        // output of the block comes straight from a flop
        next_state.ready      = (next_state.st == ST_IDLE);
        next_state.halt_ok    = !next_state.opt[OPT_HALT_OFF_BIT];
        next_state.boot_flash = next_state.opt[OPT_BOOT_FLASH_BIT];
        next_state.sec        = next_state.opt[OPT_SECURE_BIT];
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state            <= '0;
            state.st         <= ST_IDLE;
            state.core_reset <= 1'b1;
            state.rv         <= reset_image();
            state.op.addr    <= 16'h0000;
            // Decoded levels match an erased option byte
            state.ready      <= 1'b1;
            state.halt_ok    <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign flash_op               = state.op;
    assign ext_ready              = state.ready;
    assign ext_done               = state.done;
    assign ext_refused            = state.refused;
    assign ext_rdata              = state.rdata;
    assign core_reset             = state.core_reset;
    assign reset_vals             = state.rv;
    assign halt_allowed           = state.halt_ok;
    assign boot_from_flash        = state.boot_flash;
    assign secure                 = state.sec;
    assign wd_armed               = state.wd_armed;
    assign ports_force_input      = state.core_reset;
    assign g0_pullup              = state.core_reset;
    assign g2_pullup              = state.core_reset;
    assign watchdog_error_pin_out = state.g1_out;
    assign watchdog_error_pin_oe  = state.g1_oe;

endmodule : rbos_reset_ctrl

// >>> testbench/rbos_reset_ctrl_assertions.sv
// Port-level checks of the reset controller
`timescale 1ns/100ps
module rbos_reset_ctrl_assertions
    import rbos_pkg::*;
#(
    parameter logic [7:0] PROGRAM_TIMING_REG_VALUE = PROGRAM_TIMING_REG_10MHZ
) (
    // Clock, reset and stimulus
    input wire logic             mclk,
    input wire logic             rst_n,
    input wire logic             reset_pin_n,
    input wire logic             above_bor,
    input wire logic [7:0]       nonvolatile_option_byte,
    input wire logic             clk_too_slow,
    input wire rbos_req_t        ext_req,
    input wire logic             isp_user_mode,
    // Watched outputs
    input wire rbos_flash_op_t   flash_op,
    input wire logic             ext_ready,
    input wire logic             ext_done,
    input wire logic             ext_refused,
    input wire logic [7:0]       ext_rdata,
    input wire logic             core_reset,
    input wire rbos_reset_vals_t reset_vals,
    input wire logic             halt_allowed,
    input wire logic             boot_from_flash,
    input wire logic             secure,
    input wire logic             wd_armed,
    input wire logic             ports_force_input,
    input wire logic             g0_pullup,
    input wire logic             g2_pullup,
    input wire logic             watchdog_error_pin_out,
    input wire logic             watchdog_error_pin_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic lock;
    assign take = ext_ready && ext_req.valid;
    assign lock = take && secure && !isp_user_mode;

    AST_PIN_RST: assert property (
        !reset_pin_n |=> core_reset) else $error("pin reset missed");
    AST_BOR_HOLD: assert property (
        !above_bor [*2] |=> core_reset) else $error("brownout missed");
    AST_PORTS: assert property (
        core_reset |-> ports_force_input && g0_pullup && g2_pullup)
        else $error("ports not parked");
    AST_CORE_VALS: assert property (
        core_reset |-> reset_vals.pc == PC_RESET
            && reset_vals.processor_status_reg == CLEARED
            && reset_vals.segment_reg == CLEARED
            && reset_vals.wakeup_enable_reg == CLEARED
            && reset_vals.idle_timer_ctrl_reg == 8'h40
            && reset_vals.stack_ptr == 8'h6F)
        else $error("core reset image wrong");
    AST_PERIPH_VALS: assert property (
        core_reset |-> reset_vals.usart_ctrl_reg == 8'h02
            && reset_vals.isp_addr_high_reg == CLEARED
            && reset_vals.program_timing_reg == PROGRAM_TIMING_REG_VALUE
            && reset_vals.wd_window == 2'h3 && !wd_armed)
        else $error("peripheral reset image wrong");
    AST_OPT_DECODE: assert property (
        $fell(core_reset) |->
            secure == $past(nonvolatile_option_byte[5])
            && halt_allowed == !$past(nonvolatile_option_byte[1])
            && boot_from_flash == $past(nonvolatile_option_byte[0])
            && wd_armed == !$past(nonvolatile_option_byte[2]))
        else $error("option decode wrong");
    AST_CLKMON: assert property (
        wd_armed && !core_reset && clk_too_slow |=>
            watchdog_error_pin_oe && !watchdog_error_pin_out)
        else $error("clock monitor pin not low");
    AST_REFUSE: assert property (
        lock && ext_req.cmd inside {CMD_WRITE, CMD_PAGE_ERASE} |=>
            ext_refused && !flash_op.wr && !flash_op.page_erase
            ##1 ext_done) else $error("locked change not refused");
    AST_MASS: assert property (
        take && ext_req.cmd == CMD_MASS_ERASE |=>
            flash_op.mass_erase && !ext_refused ##1 ext_done)
        else $error("mass erase blocked");
    AST_SEC_READ: assert property (
        lock && ext_req.cmd == CMD_READ && ext_req.addr != 16'hFFFF
            && ext_req.addr != 16'h3FFF |=> !flash_op.rd
            ##1 ext_done && ext_rdata == 8'hFF)
        else $error("secured read leaked");
endmodule : rbos_reset_ctrl_assertions

// >>> testbench/rbos_flash_model.sv
// Flash array and stored option byte behind the controller
`timescale 1ns/100ps
module rbos_flash_model
    import rbos_pkg::*;
(
    // Clock and flash strobes
    input  wire logic           mclk,
    input  wire rbos_flash_op_t flash_op,
    // Option byte load from the bench
    input  wire logic           opt_load,
    input  wire logic [7:0]     opt_value,
    // Read data and stored option byte
    output logic [7:0]          flash_rdata,
    output logic [7:0]          opt_byte
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    logic       rd_live = 1'b0;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
        opt_byte = OPT_ERASED;
    end
    // Data stands two cycles only; otherwise a changing pattern
    assign flash_rdata = (rd_live || flash_op.rd) ?
                         mem[flash_op.addr[7:0]] : ~last;
    always @(posedge mclk) begin
        rd_live <= flash_op.rd;
        last <= flash_rdata;
        if (flash_op.wr) begin
            mem[flash_op.addr[7:0]] <= flash_op.wdata;
        end
        if (flash_op.mass_erase) begin
            opt_byte <= OPT_ERASED;
        end
        if (opt_load) begin
            opt_byte <= opt_value;
        end
    end
endmodule : rbos_flash_model

// >>> testbench/rbos_reset_ctrl_bench.sv
// Self-checking bench of the reset and security block
`timescale 1ns/100ps
module rbos_reset_ctrl_bench
    import rbos_pkg::*;
();
    localparam int DLY = 20;
    logic             mclk = 1'b0;
    logic             rst_n = 1'b0;
    logic             reset_pin_n = 1'b1;
    logic             above_trigger = 1'b0;
    logic             above_bor = 1'b0;
    logic             t0_tick = 1'b0;
    logic             clk_too_slow = 1'b0;
    logic             isp_user_mode = 1'b0;
    logic             opt_load = 1'b0;
    logic [7:0]       opt_value = 8'h00;
    rbos_req_t        ext_req = '0;
    logic [7:0]       flash_rdata, opt_byte, ext_rdata;
    rbos_flash_op_t   flash_op;
    rbos_reset_vals_t reset_vals;
    logic             ext_ready, ext_done, ext_refused, core_reset;
    logic             halt_allowed, boot_from_flash, secure, wd_armed;
    logic             g1_out, g1_oe, force_in, pu0, pu2;
    int               bad_count = 0;
    int               checked = 0;

    rbos_reset_ctrl #(.DELAY_CYC(DLY)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
        .above_trigger(above_trigger), .above_bor(above_bor),
        .nonvolatile_option_byte(opt_byte), .t0_tick(t0_tick),
        .clk_too_slow(clk_too_slow), .gpio_g1_out(1'b0),
        .gpio_g1_oe(1'b1), .ext_req(ext_req),
        .isp_user_mode(isp_user_mode), .flash_rdata(flash_rdata),
        .flash_op(flash_op), .ext_ready(ext_ready), .ext_done(ext_done),
        .ext_refused(ext_refused), .ext_rdata(ext_rdata),
        .core_reset(core_reset), .reset_vals(reset_vals),
        .halt_allowed(halt_allowed), .boot_from_flash(boot_from_flash),
        .secure(secure), .wd_armed(wd_armed),
        .ports_force_input(force_in), .g0_pullup(pu0), .g2_pullup(pu2),
        .watchdog_error_pin_out(g1_out), .watchdog_error_pin_oe(g1_oe));
    rbos_flash_model u_flash (
        .mclk(mclk), .flash_op(flash_op), .opt_load(opt_load),
        .opt_value(opt_value), .flash_rdata(flash_rdata),
        .opt_byte(opt_byte));

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask : cmp1
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic cyc;
        @(posedge mclk);
        #1;
    endtask : cyc
    // Counts cycles until the core leaves reset; a hang ends the run
    task automatic wait_free(output int n);
        n = 0;
        while (core_reset !== 1'b0) begin
            cyc();
            n++;
            if (n > 400) begin
                cmp8(8'h00, 8'hFF);
                final_report();
            end
        end
    endtask : wait_free
    task automatic pin_reset(input logic [7:0] opt);
        int n;
        @(posedge mclk);
        opt_load <= 1'b1;
        opt_value <= opt;
        reset_pin_n <= 1'b0;
        @(posedge mclk);
        opt_load <= 1'b0;
        repeat (2) cyc();
        cmp1(core_reset, 1'b1);
        cmp8(reset_vals.idle_timer_ctrl_reg, 8'h40);
        @(posedge mclk);
        reset_pin_n <= 1'b1;
        #1;
        wait_free(n);
    endtask : pin_reset
    task automatic ext_op(input rbos_cmd_t c, input logic [15:0] a,
                          input logic u, output logic [7:0] q,
                          output logic r);
        int n;
        r = 1'b0;
        n = 0;
        @(posedge mclk);
        isp_user_mode <= u;
        ext_req <= '{valid: 1'b1, cmd: c, addr: a, wdata: 8'h3C};
        @(posedge mclk);
        ext_req.valid <= 1'b0;
        #1;
        while (ext_done !== 1'b1 && n < 8) begin
            r = r | (ext_refused === 1'b1);
            cyc();
            n++;
        end
        cmp1(ext_done, 1'b1);
        q = ext_rdata;
    endtask : ext_op
    task automatic t_startup;
        int n;
        repeat (30) cyc();
        cmp1(core_reset, 1'b1);
        @(posedge mclk);
        above_trigger <= 1'b1;
        above_bor <= 1'b1;
        #1;
        wait_free(n);
        cmp1(n >= DLY + 256 && n <= DLY + 260, 1'b1);
    endtask : t_startup
    task automatic t_options;
        logic [7:0] tbl [4] = '{8'h02, 8'h04, 8'h00, 8'h01};
        foreach (tbl[i]) begin
            pin_reset(tbl[i]);
            cmp1(halt_allowed, !tbl[i][1]);
            cmp1(boot_from_flash, tbl[i][0]);
            cmp1(wd_armed, !tbl[i][2]);
            cmp1(g1_out, !tbl[i][2]);
        end
    endtask : t_options
    task automatic t_clkmon;
        int n;
        @(posedge mclk);
        clk_too_slow <= 1'b1;
        repeat (2) @(posedge mclk);
        clk_too_slow <= 1'b0;
        #1;
        cmp1(g1_out, 1'b0);
        n = 0;
        while (g1_out !== 1'b1 && n < 40) begin
            @(posedge mclk);
            t0_tick <= 1'b1;
            @(posedge mclk);
            t0_tick <= 1'b0;
            repeat (2) cyc();
            n++;
        end
        cmp1(n >= 16 && n <= 32, 1'b1);
    endtask : t_clkmon
    task automatic t_brownout;
        int n;
        logic hit;
        hit = 1'b0;
        @(posedge mclk);
        above_bor <= 1'b0;
        repeat (4) cyc();
        cmp1(core_reset, 1'b1);
        @(posedge mclk);
        above_bor <= 1'b1;
        #1;
        wait_free(n);
        // Trigger stayed up, so no power-up delay this time
        cmp1(n >= 256 && n <= 260, 1'b1);
        repeat (60) begin
            cyc();
            hit = hit | (core_reset !== 1'b0);
        end
        cmp1(hit, 1'b0);
    endtask : t_brownout
    task automatic t_security;
        logic [7:0] d;
        logic       r;
        pin_reset(8'h00);
        ext_op(CMD_READ, 16'h0010, 1'b0, d, r);
        cmp8(d, 8'hB5);
        pin_reset(8'h21);
        cmp1(secure, 1'b1);
        ext_op(CMD_READ, 16'h0010, 1'b0, d, r);
        cmp8(d, 8'hFF);
        ext_op(CMD_READ, 16'hFFFF, 1'b0, d, r);
        cmp8(d, 8'h21);
        ext_op(CMD_WRITE, 16'h0020, 1'b0, d, r);
        cmp1(r, 1'b1);
        ext_op(CMD_PAGE_ERASE, 16'h0040, 1'b0, d, r);
        cmp1(r, 1'b1);
        ext_op(CMD_WRITE, 16'h0020, 1'b1, d, r);
        cmp1(r, 1'b0);
        ext_op(CMD_MASS_ERASE, 16'h0000, 1'b0, d, r);
        cmp1(r, 1'b0);
        cmp1(secure, 1'b0);
    endtask : t_security

    initial begin
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_startup();
        t_options();
        t_clkmon();
        t_brownout();
        t_security();
        final_report();
    end
endmodule : rbos_reset_ctrl_bench

bind rbos_reset_ctrl rbos_reset_ctrl_assertions #(
    .PROGRAM_TIMING_REG_VALUE(PROGRAM_TIMING_REG_VALUE)) u_chk (
    .mclk(mclk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .above_bor(above_bor), .clk_too_slow(clk_too_slow),
    .nonvolatile_option_byte(nonvolatile_option_byte),
    .ext_req(ext_req), .isp_user_mode(isp_user_mode),
    .flash_op(flash_op), .ext_ready(ext_ready), .ext_done(ext_done),
    .ext_refused(ext_refused), .ext_rdata(ext_rdata),
    .core_reset(core_reset), .reset_vals(reset_vals),
    .halt_allowed(halt_allowed), .boot_from_flash(boot_from_flash),
    .secure(secure), .wd_armed(wd_armed),
    .ports_force_input(ports_force_input), .g0_pullup(g0_pullup),
    .g2_pullup(g2_pullup),
    .watchdog_error_pin_out(watchdog_error_pin_out),
    .watchdog_error_pin_oe(watchdog_error_pin_oe));
